// [logic/ssfc_cfg.svh]
// constants for the sensor serial frame port with crc
// What this block does
// - while chip select is high, ignore clock and data; output stays undriven
// - chip select rising ends the frame and clears all partial frame state except the latched address
// - each incoming frame has four command bits; top two are reserved
// - keep a 3-bit rolling tally of conversion data sets, wrapping after seven
// - shift one answer bit per clock while selected; undriven when deselected
// - format selector zero: frame carries one 16-bit register and regular flags
// - regular frame has twelve flag bits, copied from status except summary error
// - summary error flag is set whenever any error bit in the device is set
// - flag 11 is last frame crc error, then config lost, alerts, axes, error
// - flags 10 to 4 come from conversion and front-end flag registers
// - lowest three flags follow the flag select command of the previous frame
// - nonzero format selector: two 12-bit channels and four flag bits
// - two-channel frames continue on reads and writes until selector is zero
// - low four bits of each frame are crc x^4+x+1 seeded all ones
// - crc runs serially msb first over 28 bits then four zeros
// - incoming crc is checked before a write; mismatching writes are dropped
// - on incoming crc error in crc bits 3 to 1, invert the last outgoing crc bit in that frame
// - crc checking is on after reset; one fixed command word turns it off
// - regular read is answered in the same frame with the addressed register
// - two-channel format still acts on incoming address and data, but answers with the channel pair
// - regular write frame answers with sixteen zero data bits
// - output changes on falling clock edge, input sampled on rising edge
// - every frame is exactly 32 bits, always started by the controller
`ifndef SSFC_CFG_SVH
`define SSFC_CFG_SVH
`define SSFC_FRAME_BITS 6'h20
`define SSFC_LAST_RX 6'h1F
`define SSFC_ADDR_RX 6'h07
`define SSFC_LAST_TX 5'h1F
`define SSFC_INV_TX 5'h1E
`define SSFC_RW_BIT 31
`define SSFC_ADDR_HI 30
`define SSFC_ADDR_LO 24
`define SSFC_DATA_HI 23
`define SSFC_DATA_LO 8
`define SSFC_CMD0_BIT 4
`define SSFC_FLAG_SELECT_CMD_BIT 5
`define SSFC_CRC_SEED 4'hF
`define SSFC_CRC_OFF_WORD 32'h0F000407
`define SSFC_CS_IDLE 1'h1
`endif

// [logic/ssfc_pkg.sv]
// types of the sensor serial frame port
package ssfc_pkg;
   typedef enum logic [0:0] {
      SSFC_FMT_REGULAR = 1'b0,
      SSFC_FMT_DUAL = 1'b1
   } ssfc_fmt_t;
   typedef logic [27:0] ssfc_payload_t;
endpackage

// [logic/ssfc_port.sv]
// peripheral end of the 32-bit serial frame port with crc
`timescale 1ns/100ps
`include "ssfc_cfg.svh"
module ssfc_port
   import ssfc_pkg::*;
#(
   parameter int ERR_W = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_n_o,
   input wire logic [2:0] data_type_i,
   input wire logic [3:0] conversion_flags_reg_i,
   input wire logic cfg_lost_i,
   input wire logic alert_pin_flag_hi_i,
   input wire logic alert_pin_flag_lo_i,
   input wire logic [ERR_W-1:0] error_bits_i,
   input wire logic [2:0] alt_flags_i,
   input wire logic conv_done_i,
   input wire logic [11:0] ch_a_i,
   input wire logic [11:0] ch_b_i,
   output logic rd_en_o,
   output logic [6:0] rd_addr_o,
   input wire logic [15:0] rd_data_i,
   output logic wr_en_o,
   output logic [6:0] wr_addr_o,
   output logic [15:0] wr_data_o,
   output logic conv_start_o,
   output logic flag_select_o,
   output logic crc_en_o,
   output logic prev_crc_err_o
);

   function automatic logic [3:0] crc4(input ssfc_payload_t pay);
      logic [31:0] pad;
      logic [3:0] c;
      logic inv;
      pad = {pay, 4'h0};
      c = `SSFC_CRC_SEED;
      inv = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         inv = pad[i] ^ c[3];
         c = {c[2:1], c[0] ^ inv, inv};
      end
      return c;
   endfunction

   // ---- link side, clocked by sck ----
   logic [5:0] rx_cnt_ff;
   logic [31:0] rx_sh_ff;
   logic [31:0] rx_word_ff;
   logic done_tgl_ff;
   logic [6:0] addr_lk_ff;
   logic rd_req_ff;
   logic is_rd_ff;
   logic [4:0] tx_idx_ff;
   logic inv_ff;
   logic [3:0] rx_pre_crc;
   ssfc_payload_t tx_pay;
   logic [3:0] tx_crc;
   logic [31:0] tx_word;

   // ---- system side, clocked by clk ----
   logic cs_s1_ff;
   logic cs_s2_ff;
   logic ft_s1_ff;
   logic ft_s2_ff;
   logic ft_s3_ff;
   logic rq_s1_ff;
   logic rq_s2_ff;
   logic frame_evt;
   logic rx_ok;
   logic rx_take;
   logic rd_en_ff;
   logic [6:0] rd_addr_ff;
   logic [15:0] rd_hold_ff;
   logic wr_en_ff;
   logic [6:0] wr_addr_ff;
   logic [15:0] wr_data_ff;
   logic conv_start_ff;
   logic flag_sel_ff;
   logic crc_en_ff;
   logic prev_crc_err_ff;
   logic [2:0] set_cnt_ff;
   logic err_sum;
   logic [2:0] stat_lo;
   ssfc_fmt_t snap_fmt_ff;
   logic [11:0] snap_stat12_ff;
   logic [3:0] snap_stat4_ff;
   logic [11:0] snap_ch_a_ff;
   logic [11:0] snap_ch_b_ff;
   logic snap_crc_en_ff;

   // chip select high holds the receive counter, shifter and read flags in reset
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         rx_cnt_ff <= 6'h00;
         rx_sh_ff <= 32'h00000000;
         rd_req_ff <= 1'b0;
         is_rd_ff <= 1'b0;
      end else begin
         rx_sh_ff <= {rx_sh_ff[30:0], sdi_i};
         // bits past the 32nd are shifted but never acted on
         if (rx_cnt_ff != `SSFC_FRAME_BITS) begin
            rx_cnt_ff <= rx_cnt_ff + 6'h01;
         end
         if (rx_cnt_ff == `SSFC_ADDR_RX) begin
            rd_req_ff <= rx_sh_ff[6];
            is_rd_ff <= rx_sh_ff[6];
         end
      end
   end

   // word and address kept across chip select so the clk side can read them late
   always_ff @(posedge sck_i) begin
      if (rx_cnt_ff == `SSFC_LAST_RX) begin
         rx_word_ff <= {rx_sh_ff[30:0], sdi_i};
      end
      if (rx_cnt_ff == `SSFC_ADDR_RX) begin
         addr_lk_ff <= {rx_sh_ff[5:0], sdi_i};
      end
   end

   // only a 32nd edge flips the toggle, so a cut frame raises no event
   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         done_tgl_ff <= 1'b0;
      end else if (rx_cnt_ff == `SSFC_LAST_RX) begin
         done_tgl_ff <= ~done_tgl_ff;
      end
   end

   // check of the first three crc bits; bit 0 arrives after it is already sent
   assign rx_pre_crc = crc4(rx_sh_ff[30:3]);

   always_ff @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         tx_idx_ff <= 5'h00;
         inv_ff <= 1'b0;
      end else begin
         if (tx_idx_ff != `SSFC_LAST_TX) begin
            tx_idx_ff <= tx_idx_ff + 5'h01;
         end
         if (tx_idx_ff == `SSFC_INV_TX) begin
            inv_ff <= snap_crc_en_ff & (rx_pre_crc[3:1] != rx_sh_ff[2:0]);
         end
      end
   end

   // snapshot registers are frozen while the frame runs; the read holding register loads mid-frame, before its bits go out
   always_comb begin
      if (snap_fmt_ff == SSFC_FMT_DUAL) begin
         tx_pay = {snap_stat4_ff, snap_ch_a_ff, snap_ch_b_ff};
      end else if (is_rd_ff) begin
         tx_pay = {snap_stat12_ff, rd_hold_ff};
      end else begin
         tx_pay = {snap_stat12_ff, 16'h0000};
      end
   end

   assign tx_crc = crc4(tx_pay);
   assign tx_word = {tx_pay, tx_crc[3:1], tx_crc[0] ^ inv_ff};
   assign sdo_o = tx_word[5'h1F - tx_idx_ff];
   // pad enable follows the pin directly; a synchronised copy would be late
   assign sdo_oe_n_o = cs_n_i;

   // ---- crossings into clk ----
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_s1_ff <= `SSFC_CS_IDLE;
         cs_s2_ff <= `SSFC_CS_IDLE;
         ft_s1_ff <= 1'b0;
         ft_s2_ff <= 1'b0;
         ft_s3_ff <= 1'b0;
         rq_s1_ff <= 1'b0;
         rq_s2_ff <= 1'b0;
      end else begin
         cs_s1_ff <= cs_n_i;
         cs_s2_ff <= cs_s1_ff;
         ft_s1_ff <= done_tgl_ff;
         ft_s2_ff <= ft_s1_ff;
         ft_s3_ff <= ft_s2_ff;
         rq_s1_ff <= rd_req_ff;
         rq_s2_ff <= rq_s1_ff;
      end
   end

   assign frame_evt = ft_s2_ff ^ ft_s3_ff;
   assign rx_ok = (crc4(rx_word_ff[31:4]) == rx_word_ff[3:0]);
   assign rx_take = frame_evt & (rx_ok | ~crc_en_ff);

   // register fetch: rd_data_i must answer rd_addr_o in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_en_ff <= 1'b0;
         rd_addr_ff <= 7'h00;
         rd_hold_ff <= 16'h0000;
      end else begin
         rd_en_ff <= rq_s2_ff;
         if (rq_s2_ff) begin
            rd_addr_ff <= addr_lk_ff;
         end
         if (rd_en_ff) begin
            rd_hold_ff <= rd_data_i;
         end
      end
   end

   // reserved command bits 7 and 6 are accepted and ignored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_en_ff <= 1'b0;
         wr_addr_ff <= 7'h00;
         wr_data_ff <= 16'h0000;
         conv_start_ff <= 1'b0;
         flag_sel_ff <= 1'b0;
      end else begin
         wr_en_ff <= rx_take & ~rx_word_ff[`SSFC_RW_BIT];
         conv_start_ff <= rx_take & rx_word_ff[`SSFC_CMD0_BIT];
         if (rx_take) begin
            wr_addr_ff <= rx_word_ff[`SSFC_ADDR_HI:`SSFC_ADDR_LO];
            wr_data_ff <= rx_word_ff[`SSFC_DATA_HI:`SSFC_DATA_LO];
            flag_sel_ff <= rx_word_ff[`SSFC_FLAG_SELECT_CMD_BIT];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crc_en_ff <= 1'b1;
      end else if (frame_evt && rx_ok && rx_word_ff == `SSFC_CRC_OFF_WORD) begin
         crc_en_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_crc_err_ff <= 1'b0;
      end else if (frame_evt) begin
         prev_crc_err_ff <= ~rx_ok;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         set_cnt_ff <= 3'h0;
      end else if (conv_done_i) begin
         set_cnt_ff <= set_cnt_ff + 3'h1;
      end
   end

   assign err_sum = (|error_bits_i) | prev_crc_err_ff;
   assign stat_lo = flag_sel_ff ? alt_flags_i : set_cnt_ff;

   // snapshot only refreshes while deselected, so the frame sees stable words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snap_fmt_ff <= SSFC_FMT_REGULAR;
         snap_stat12_ff <= 12'h000;
         snap_stat4_ff <= 4'h0;
         snap_ch_a_ff <= 12'h000;
         snap_ch_b_ff <= 12'h000;
         snap_crc_en_ff <= 1'b1;
      end else if (cs_s2_ff) begin
         snap_fmt_ff <= (data_type_i != 3'h0) ? SSFC_FMT_DUAL : SSFC_FMT_REGULAR;
         snap_stat12_ff <= {prev_crc_err_ff, cfg_lost_i, alert_pin_flag_hi_i,
                            alert_pin_flag_lo_i, conversion_flags_reg_i,
                            err_sum, stat_lo};
         snap_stat4_ff <= {err_sum, stat_lo};
         snap_ch_a_ff <= ch_a_i;
         snap_ch_b_ff <= ch_b_i;
         snap_crc_en_ff <= crc_en_ff;
      end
   end

   assign rd_en_o = rd_en_ff;
   assign rd_addr_o = rd_addr_ff;
   assign wr_en_o = wr_en_ff;
   assign wr_addr_o = wr_addr_ff;
   assign wr_data_o = wr_data_ff;
   assign conv_start_o = conv_start_ff;
   assign flag_select_o = flag_sel_ff;
   assign crc_en_o = crc_en_ff;
   assign prev_crc_err_o = prev_crc_err_ff;

   // ---- checks ----
   sequence s_take;
      rx_take;
   endsequence

   sequence s_fetch;
      $rose(rq_s2_ff) ##1 rd_en_o;
   endsequence

   a_wr_crc_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_en_o |-> $past(rx_ok) || !$past(crc_en_ff))
      else $error("write issued from a frame with bad crc");

   a_prev_crc_latch: assert property (@(posedge clk_i) disable iff (rst_i)
      frame_evt |=> prev_crc_err_o == !$past(rx_ok))
      else $error("previous frame crc flag not latched");

   a_crc_off_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
      (frame_evt && rx_ok && rx_word_ff == `SSFC_CRC_OFF_WORD) |=> !crc_en_o)
      else $error("crc disable word not honoured");

   a_count_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
      (conv_done_i && set_cnt_ff == 3'h7) |=> set_cnt_ff == 3'h0)
      else $error("set count did not wrap to zero");

   a_flag_select: assert property (@(posedge clk_i) disable iff (rst_i)
      s_take |=> flag_sel_ff == $past(rx_word_ff[`SSFC_FLAG_SELECT_CMD_BIT]))
      else $error("flag select not taken from frame");

   a_read_fetch: assert property (@(posedge clk_i) disable iff (rst_i)
      s_fetch |=> rd_hold_ff == $past(rd_data_i))
      else $error("read data not captured after fetch");

   a_no_stray_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
      !frame_evt |=> !wr_en_o && !conv_start_o)
      else $error("command without a complete frame");

   a_err_summary: assert property (@(posedge clk_i) disable iff (rst_i)
      (cs_s2_ff && (|error_bits_i)) |=> snap_stat12_ff[3] && snap_stat4_ff[3])
      else $error("summary error flag missing");

   a_dual_format: assert property (@(posedge clk_i) disable iff (rst_i)
      (cs_s2_ff && data_type_i != 3'h0) |=> snap_fmt_ff == SSFC_FMT_DUAL)
      else $error("two-channel format not selected");

   a_write_zeros: assert property (@(negedge sck_i) disable iff (cs_n_i)
      (tx_idx_ff inside {[5'd12:5'd27]} && !is_rd_ff && snap_fmt_ff == SSFC_FMT_REGULAR)
      |-> !sdo_o)
      else $error("write frame data field not zero");

   // recomputed from the whole received word, but like the early check it compares crc bits 3 to 1 only
   a_crc_invert: assert property (@(negedge sck_i) disable iff (cs_n_i)
      (tx_idx_ff == `SSFC_LAST_TX) |-> (sdo_o ^ tx_crc[0]) ==
      (snap_crc_en_ff && ((crc4(rx_sh_ff[31:4]) & 4'hE) != (rx_sh_ff[3:0] & 4'hE))))
      else $error("last crc bit not inverted on error");

endmodule

// [bench/ssfc_ctrl_model.sv]
// controller model that clocks 32-bit frames through the sensor port
`timescale 1ns/100ps
module ssfc_ctrl_model (
   output logic sck_o,
   output logic cs_n_o,
   output logic sdi_o,
   input wire logic sdo_i
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b0;
      sdi_o = 1'b0;
      // one real deselect edge, so the link side leaves its unknown start state
      #1;
      cs_n_o = 1'b1;
   end
   // clock stands low between frames; data line flips once released
   task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
      rx = 32'h00000000;
      cs_n_o = 1'b0;
      sdi_o = tx[31];
      #64; // port freezes its snapshot before the first edge
      for (int k = 0; k < nbits; k++) begin
         sck_o = 1'b1;
         rx[31-k] = sdo_i;
         #16;
         sck_o = 1'b0;
         if (k < 31) sdi_o = tx[30-k];
         #16;
      end
      cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
   endtask
endmodule

// [bench/ssfc_port_test.sv]
// self-checking bench for the serial frame port
`timescale 1ns/100ps
`include "ssfc_cfg.svh"
module ssfc_port_test;
   import ssfc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b0;
   logic sck, cs_n, sdi, sdo, sdo_oe_n, cfg_lost = 1'b0, al_hi = 1'b0, al_lo = 1'b0, conv_done = 1'b0;
   logic [2:0] data_type = 3'h0;
   logic [2:0] alt_flags = 3'h0;
   logic [3:0] conv_flags = 4'h0;
   logic [7:0] err_bits = 8'h00;
   logic [11:0] ch_a = 12'h000;
   logic [11:0] ch_b = 12'h000;
   logic rd_en, wr_en, conv_start, flag_sel, crc_en, prev_err;
   logic [6:0] rd_addr, wr_addr;
   logic [15:0] rd_data, wr_data;
   logic m_prev = 1'b0;
   logic m_fsel = 1'b0;
   logic m_crc_en = 1'b1;
   logic [2:0] m_cnt = 3'h0;
   logic m_rd = 1'b0;
   logic [6:0] m_addr = 7'h00;
   int seed = 32'h3b43;
   int err_count = 0;
   int check_count = 0;

   always #10 clk_i = ~clk_i;
   // register file stand-in: answers in the same cycle
   assign rd_data = {rd_addr, ~rd_addr, 2'h1};

   ssfc_port ssfc_port_i (.clk_i(clk_i), .rst_i(rst_i), .sck_i(sck), .cs_n_i(cs_n), .sdi_i(sdi),
      .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .data_type_i(data_type), .conversion_flags_reg_i(conv_flags),
      .cfg_lost_i(cfg_lost), .alert_pin_flag_hi_i(al_hi), .alert_pin_flag_lo_i(al_lo),
      .error_bits_i(err_bits), .alt_flags_i(alt_flags), .conv_done_i(conv_done), .ch_a_i(ch_a),
      .ch_b_i(ch_b), .rd_en_o(rd_en), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .wr_en_o(wr_en),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data), .conv_start_o(conv_start), .flag_select_o(flag_sel),
      .crc_en_o(crc_en), .prev_crc_err_o(prev_err));
   ssfc_ctrl_model ssfc_ctrl_model_i (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));

   // the pad must be driving at every rising clock edge the controller gives
   always @(posedge sck) check_bit(sdo_oe_n, 1'b0);

   // a fetch may only appear for a read frame, at the address it carried
   always @(negedge clk_i) begin
      if (rd_en === 1'b1) begin
         check_word({25'h0000000, rd_addr}, {25'h0000000, m_addr});
         check_bit(m_rd, 1'b1);
      end
   end

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_word({31'h00000000, got}, {31'h00000000, exp});
   endtask

   task automatic complete_run();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   function automatic logic [3:0] crc4(input logic [27:0] p);
      logic [31:0] w;
      logic [3:0] c;
      logic inv;
      w = {p, 4'h0};
      c = 4'hF;
      for (int i = 31; i >= 0; i--) begin
         inv = w[i] ^ c[3];
         c = {c[2:1], c[0] ^ inv, inv};
      end
      return c;
   endfunction

   function automatic logic [31:0] exp_rx(input logic rd, input logic [6:0] a, input logic bad);
      logic [27:0] p;
      logic esum;
      logic [2:0] low;
      esum = (|err_bits) | m_prev;
      low = m_fsel ? alt_flags : m_cnt;
      if (data_type != 3'h0) p = {esum, low, ch_a, ch_b};
      else p = {m_prev, cfg_lost, al_hi, al_lo, conv_flags, esum, low, rd ? {a, ~a, 2'h1} : 16'h0000};
      return {p, crc4(p) ^ {3'h0, bad & m_crc_en}};
   endfunction

   // new status values settle into the port's snapshot before the next frame
   task automatic stir(input logic [2:0] dt);
      @(negedge clk_i);
      data_type = dt;
      {cfg_lost, al_hi, al_lo, conv_flags, alt_flags} = 10'($random(seed));
      err_bits = (($random(seed) & 3) == 0) ? 8'($random(seed)) : 8'h00;
      {ch_a, ch_b} = 24'($random(seed));
      repeat ($random(seed) & 3) begin
         @(negedge clk_i);
         conv_done = 1'b1;
         @(negedge clk_i);
         conv_done = 1'b0;
         m_cnt++;
      end
      repeat (4) @(negedge clk_i);
   endtask

   task automatic run_frame(input logic rd, input logic [6:0] a, input logic [15:0] d, input logic [3:0] cmd,
                            input logic bad, input int nbits);
      logic [31:0] tx, rx, ex;
      logic full, acc;
      int nwr, ncs;
      tx[31:4] = {rd, a, d, cmd};
      tx[3:0] = crc4(tx[31:4]) ^ {bad, 3'h0};
      ex = exp_rx(rd, a, bad);
      full = (nbits == 32);
      acc = full && (!bad || !m_crc_en);
      nwr = 0;
      ncs = 0;
      m_rd = rd;
      m_addr = a;
      ssfc_ctrl_model_i.frame(tx, nbits, rx);
      // let the deselect reach the pad enable before it is looked at
      #1;
      if (full) check_word(rx, ex);
      check_bit(sdo_oe_n, 1'b1);
      repeat (12) begin
         @(posedge clk_i);
         #1;
         if (wr_en === 1'b1) begin
            nwr++;
            check_word({9'h000, wr_addr, wr_data}, {9'h000, a, d});
         end
         ncs += (conv_start === 1'b1);
      end
      check_word(nwr, {31'h00000000, acc & !rd});
      check_word(ncs, {31'h00000000, acc & cmd[0]});
      if (full) m_prev = bad;
      if (acc) m_fsel = cmd[1];
      if (acc && tx == `SSFC_CRC_OFF_WORD) m_crc_en = 1'b0;
      check_bit(prev_err, m_prev);
      check_bit(flag_sel, m_fsel);
      check_bit(crc_en, m_crc_en);
   endtask

   initial begin
      #400us;
      err_count++;
      complete_run();
   end

   initial begin
      // a real rising edge of reset clears the asynchronously reset toggle
      #1;
      rst_i = 1'b1;
      repeat (10) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge clk_i);
      check_bit(crc_en, 1'b1);
      check_bit(sdo_oe_n, 1'b1);
      for (int i = 0; i < 30; i++) begin
         stir((i >= 16 && i < 21) ? 3'(1 + i % 7) : 3'h0);
         // short frames now and then, cut at a random bit count
         run_frame($random(seed), $random(seed), $random(seed), $random(seed), ($random(seed) & 3) == 0,
                   (i % 6 == 5) ? 1 + ($random(seed) & 15) : 32);
      end
      stir(3'h0);
      run_frame(1'b0, 7'h0F, 16'h0004, 4'h0, 1'b0, 32);
      stir(3'h0);
      run_frame(1'b0, 7'h15, 16'hA5C3, 4'h3, 1'b1, 32);
      stir(3'h0);
      run_frame(1'b1, 7'h2A, 16'h0000, 4'h0, 1'b0, 32);
      complete_run();
   end
endmodule
